//--- iqwg_pkg.sv
// Shared constants for the waveform generator host port and its driver
//
// Overview of operation
// - Address byte, then data bytes to consecutive registers
// - Deselect computes 15-bit sum, MSB marks valid
// - Twenty-six registers from address zero, all summed
// - Sum ready after five plus one-per-register clocks
// - Host waits thirty-one sample clocks before reselect
// - First returned bytes: previous checksum high, low
// - Then four test bytes; the six-byte sequence repeats until deselect
// - Sample clock times the differential sample line
// - Source changes on rise, device captures on fall
// - Five one bits, then frame bit I=1, Q=0
// - Sixteen data bits, zero fill after every four
// - Frames exactly 100 bits, zero padding after the Q word
// - MSB first, I word before Q word
// - Select low routes generator waveforms, else auxiliary
// - Active-low master reset restores initial state
`default_nettype none
package iqwg_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_CLK_HZ = 4800000;
  // Nearest whole half period to the nominal rate, a little fast
  localparam int SCLK_HALF = CLK_HZ / (2 * SAMPLE_CLK_HZ);
  localparam int SPI_HALF = 8;
  localparam int NUM_REGS = 26;
  localparam int SYNC_CYCLES = 5;
  localparam int CKS_CYCLES = SYNC_CYCLES + NUM_REGS;
  localparam int GUARD_NS = 6460;
  localparam int GUARD_CYC = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKS_VALID_BIT = 15;
  localparam int FRAME_BITS = 100;
  localparam int PORTION_BITS = 26;
  localparam int READ_SEQ_LEN = 6;
  localparam logic [4:0] WORD_SYNC = 5'h1f;
  localparam logic [15:0] CKS_RESET = 16'h0000;
  // Test register contents are arbitrary
  localparam logic [7:0] TEST_BYTE0 = 8'h5a;
  localparam logic [7:0] TEST_BYTE1 = 8'ha5;
  localparam logic [7:0] TEST_BYTE2 = 8'h3c;
  localparam logic [7:0] TEST_BYTE3 = 8'hc3;
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 4;

  // 16 data bits with a zero after every nibble
  function automatic logic [19:0] iqwg_fill(input logic [15:0] d);
    iqwg_fill = {d[15:12], 1'b0, d[11:8], 1'b0, d[7:4], 1'b0, d[3:0], 1'b0};
  endfunction : iqwg_fill

  function automatic logic [15:0] iqwg_unfill(input logic [19:0] f);
    iqwg_unfill = {f[19:16], f[14:11], f[9:6], f[4:1]};
  endfunction : iqwg_unfill
endpackage : iqwg_pkg
`default_nettype wire

//--- iqwg_link_if.sv
// Pin-level link between the digital board and the waveform generator
`timescale 1ns/1ps
`default_nettype none
interface iqwg_link_if;
  logic spi_sck;
  logic spi_mosi;
  logic spi_miso_o;
  logic spi_miso_oe_n;
  logic spi_miso;
  logic gen_select_n;
  logic gen_reset_n;
  logic sample_clock_p;
  logic sample_clock_n;
  logic sample_data_p;
  logic sample_data_n;
  logic waveform_source_select;

  // Shared data-out line idles high when nobody drives it
  assign spi_miso = spi_miso_oe_n ? 1'b1 : spi_miso_o;

  modport dev (
    input spi_sck, spi_mosi, gen_select_n, gen_reset_n, sample_clock_p, sample_clock_n,
    input sample_data_p, sample_data_n, waveform_source_select,
    output spi_miso_o, spi_miso_oe_n
  );
  modport host (
    output spi_sck, spi_mosi, gen_select_n, gen_reset_n, sample_clock_p, sample_clock_n,
    output sample_data_p, sample_data_n, waveform_source_select,
    input spi_miso
  );
endinterface : iqwg_link_if
`default_nettype wire

//--- iqwg_device.sv
// Generator end: register port, checksum, sample deframer and sample FIFO
`timescale 1ns/1ps
`default_nettype none
module iqwg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : iqwg_fifo

module iqwg_device
  import iqwg_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  iqwg_link_if.dev LINK,
  output logic [15:0] I_DATA,
  output logic [15:0] Q_DATA,
  output logic SAMPLE_VALID,
  input wire logic SAMPLE_READY,
  output logic SAMPLE_OVERFLOW,
  output logic [15:0] CHECKSUM,
  output logic CHECKSUM_BUSY,
  output logic ROUTE_AUX
);
  logic [1:0] sck_s, mosi_s, sel_s, grst_s, clkp_s, clkn_s, datp_s, datn_s, src_s;
  logic rst;
  logic sck_d_reg, sel_d_reg, sclk_d_reg;
  logic sck_rise, sck_fall, sel_fall, sel_rise, sclk_fall;
  logic [7:0] regs [NUM_REGS];
  logic [7:0] rx_sh_reg, tx_sh_reg;
  logic [2:0] bit_cnt_reg;
  logic have_addr_reg;
  logic [7:0] addr_reg;
  logic [2:0] seq_reg;
  logic [15:0] cks_reg, acc_reg;
  logic cks_busy_reg;
  logic [4:0] cks_cnt_reg;
  logic [PORTION_BITS-1:0] win_reg;
  logic [15:0] i_hold_reg;
  logic i_seen_reg;
  logic push_reg;
  logic [31:0] push_data_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic ovf_reg;
  logic route_reg;
  logic [7:0] rx_byte;
  logic [PORTION_BITS-1:0] win_next;

  function automatic logic [7:0] read_byte(input logic [2:0] idx, input logic [15:0] c);
    case (idx)
      3'h0: read_byte = c[15:8];
      3'h1: read_byte = c[7:0];
      3'h2: read_byte = TEST_BYTE0;
      3'h3: read_byte = TEST_BYTE1;
      3'h4: read_byte = TEST_BYTE2;
      default: read_byte = TEST_BYTE3;
    endcase
  endfunction : read_byte

  // Two-stage synchronisers for every pin
  always_ff @(posedge CLK) begin
    sck_s <= {sck_s[0], LINK.spi_sck};
    mosi_s <= {mosi_s[0], LINK.spi_mosi};
    sel_s <= {sel_s[0], LINK.gen_select_n};
    clkp_s <= {clkp_s[0], LINK.sample_clock_p};
    clkn_s <= {clkn_s[0], LINK.sample_clock_n};
    datp_s <= {datp_s[0], LINK.sample_data_p};
    datn_s <= {datn_s[0], LINK.sample_data_n};
    src_s <= {src_s[0], LINK.waveform_source_select};
  end

  // Reset pin chain clears with RSTN so rst is never unknown
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      grst_s <= 2'b00;
    end else begin
      grst_s <= {grst_s[0], LINK.gen_reset_n};
    end
  end

  assign rst = !RSTN || !grst_s[1];

  always_ff @(posedge CLK) begin
    if (rst) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s[1];
      sel_d_reg <= sel_s[1];
      sclk_d_reg <= clkp_s[1] && !clkn_s[1];
    end
  end

  assign sck_rise = sck_s[1] && !sck_d_reg && !sel_s[1];
  assign sck_fall = !sck_s[1] && sck_d_reg && !sel_s[1];
  assign sel_fall = !sel_s[1] && sel_d_reg;
  assign sel_rise = sel_s[1] && !sel_d_reg;
  assign sclk_fall = sclk_d_reg && !(clkp_s[1] && !clkn_s[1]);
  assign rx_byte = {rx_sh_reg[6:0], mosi_s[1]};

  // Register writes: address byte then consecutive data bytes
  always_ff @(posedge CLK) begin
    if (rst) begin
      rx_sh_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      have_addr_reg <= 1'b0;
      addr_reg <= 8'h00;
      for (int k = 0; k < NUM_REGS; k++) begin
        regs[k] <= 8'h00;
      end
    end else if (sel_fall) begin
      bit_cnt_reg <= 3'h0;
      have_addr_reg <= 1'b0;
    end else if (sck_rise) begin
      rx_sh_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        if (!have_addr_reg) begin
          addr_reg <= rx_byte;
          have_addr_reg <= 1'b1;
        end else begin
          if (addr_reg < 8'(NUM_REGS)) begin
            regs[addr_reg[4:0]] <= rx_byte;
          end
          addr_reg <= addr_reg + 8'h01;
        end
      end
    end
  end

  // Read-back: checksum pair then four test bytes, cyclic
  always_ff @(posedge CLK) begin
    if (rst) begin
      tx_sh_reg <= 8'h00;
      seq_reg <= 3'h0;
      LINK.spi_miso_o <= 1'b1;
      LINK.spi_miso_oe_n <= 1'b1;
    end else if (sel_fall) begin
      tx_sh_reg <= read_byte(3'h0, cks_reg);
      seq_reg <= 3'h1;
      LINK.spi_miso_o <= cks_reg[15];
      LINK.spi_miso_oe_n <= 1'b0;
    end else if (sel_rise) begin
      LINK.spi_miso_oe_n <= 1'b1;
    end else if (sck_fall) begin
      if (bit_cnt_reg == 3'h0) begin
        tx_sh_reg <= read_byte(seq_reg, cks_reg);
        LINK.spi_miso_o <= 1'(read_byte(seq_reg, cks_reg) >> 7);
        seq_reg <= (seq_reg == 3'(READ_SEQ_LEN - 1)) ? 3'h0 : seq_reg + 3'h1;
      end else begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        LINK.spi_miso_o <= tx_sh_reg[6];
      end
    end
  end

  // Checksum over all registers on the sample clock after deselect
  always_ff @(posedge CLK) begin
    if (rst) begin
      cks_reg <= CKS_RESET;
      acc_reg <= 16'h0000;
      cks_busy_reg <= 1'b0;
      cks_cnt_reg <= 5'h00;
    end else if (sel_rise) begin
      cks_busy_reg <= 1'b1;
      cks_cnt_reg <= 5'h00;
      acc_reg <= 16'h0000;
    end else if (cks_busy_reg && sel_fall) begin
      cks_busy_reg <= 1'b0;
      cks_reg <= {1'b0, acc_reg[14:0]};
    end else if (cks_busy_reg && sclk_fall) begin
      cks_cnt_reg <= cks_cnt_reg + 5'h01;
      if (cks_cnt_reg >= 5'(SYNC_CYCLES)) begin
        acc_reg <= acc_reg + {8'h00, regs[5'(cks_cnt_reg - 5'(SYNC_CYCLES))]};
      end
      if (cks_cnt_reg == 5'(CKS_CYCLES - 1)) begin
        cks_busy_reg <= 1'b0;
        cks_reg <= {1'b1, 15'(acc_reg + {8'h00, regs[NUM_REGS-1]})};
      end
    end
  end

  // Deframer: 26-bit window over the captured sample bits
  assign win_next = {win_reg[PORTION_BITS-2:0], datp_s[1] && !datn_s[1]};

  always_ff @(posedge CLK) begin
    if (rst) begin
      win_reg <= '0;
      i_hold_reg <= 16'h0000;
      i_seen_reg <= 1'b0;
      push_reg <= 1'b0;
      push_data_reg <= 32'h00000000;
      ovf_reg <= 1'b0;
    end else begin
      if (push_reg && fifo_in_ready) begin
        push_reg <= 1'b0;
      end
      if (sclk_fall) begin
        win_reg <= win_next;
        // A real sync follows a zero bit; rejects the I sync shifted by one
        if (win_next[25:21] == WORD_SYNC && !win_reg[PORTION_BITS-1]) begin
          if (win_next[20]) begin
            i_hold_reg <= iqwg_unfill(win_next[19:0]);
            i_seen_reg <= 1'b1;
          end else if (i_seen_reg) begin
            i_seen_reg <= 1'b0;
            push_data_reg <= {i_hold_reg, iqwg_unfill(win_next[19:0])};
            push_reg <= 1'b1;
            ovf_reg <= push_reg && !fifo_in_ready;
          end
        end
      end
    end
  end

  iqwg_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(rst),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .in_data(push_data_reg),
    .out_valid(fifo_out_valid),
    .out_ready(SAMPLE_READY),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge CLK) begin
    if (rst) begin
      route_reg <= 1'b0;
    end else begin
      route_reg <= src_s[1];
    end
  end

  assign I_DATA = fifo_out_data[31:16];
  assign Q_DATA = fifo_out_data[15:0];
  assign SAMPLE_VALID = fifo_out_valid;
  assign SAMPLE_OVERFLOW = ovf_reg;
  assign CHECKSUM = cks_reg;
  assign CHECKSUM_BUSY = cks_busy_reg;
  assign ROUTE_AUX = route_reg;
endmodule : iqwg_device
`default_nettype wire

//--- iqwg_host.sv
// Digital board end: register session driver and framed sample source
`timescale 1ns/1ps
`default_nettype none
module iqwg_host
  import iqwg_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  iqwg_link_if.host LINK,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_BYTE,
  input wire logic WR_LAST,
  output logic WR_READY,
  output logic [7:0] RD_BYTE,
  output logic RD_VALID,
  input wire logic [15:0] S_I,
  input wire logic [15:0] S_Q,
  input wire logic S_VALID,
  output logic S_READY,
  input wire logic USE_AUX,
  input wire logic GEN_RESET
);
  typedef enum {HS_IDLE, HS_SHIFT, HS_WAIT, HS_GUARD} iqwg_hstate_t;
  iqwg_hstate_t st_reg;
  logic [1:0] miso_s;
  logic [3:0] ph_reg;
  logic [2:0] bitn_reg;
  logic [7:0] tx_reg, rx_reg;
  logic last_reg;
  logic [9:0] guard_reg;
  logic [3:0] sdiv_reg;
  logic [6:0] fbit_reg;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [15:0] cur_i_reg, cur_q_reg;

  always_ff @(posedge CLK) begin
    miso_s <= {miso_s[0], LINK.spi_miso};
  end

  // Register session engine
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_reg <= HS_IDLE;
      ph_reg <= 4'h0;
      bitn_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      last_reg <= 1'b0;
      guard_reg <= 10'h000;
      WR_READY <= 1'b1;
      RD_BYTE <= 8'h00;
      RD_VALID <= 1'b0;
      LINK.gen_select_n <= 1'b1;
      LINK.spi_sck <= 1'b0;
      LINK.spi_mosi <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      case (st_reg)
        HS_IDLE, HS_WAIT: begin
          if (WR_VALID && WR_READY) begin
            WR_READY <= 1'b0;
            st_reg <= HS_SHIFT;
            tx_reg <= WR_BYTE;
            last_reg <= WR_LAST;
            LINK.spi_mosi <= WR_BYTE[7];
            LINK.gen_select_n <= 1'b0;
            ph_reg <= 4'h0;
            bitn_reg <= 3'h0;
          end
        end
        HS_SHIFT: begin
          ph_reg <= ph_reg + 4'h1;
          if (ph_reg == 4'(SPI_HALF - 1)) begin
            ph_reg <= 4'h0;
            if (!LINK.spi_sck) begin
              LINK.spi_sck <= 1'b1;
              rx_reg <= {rx_reg[6:0], miso_s[1]};
            end else begin
              LINK.spi_sck <= 1'b0;
              tx_reg <= {tx_reg[6:0], 1'b0};
              LINK.spi_mosi <= tx_reg[6];
              bitn_reg <= bitn_reg + 3'h1;
              if (bitn_reg == 3'h7) begin
                RD_BYTE <= rx_reg;
                RD_VALID <= 1'b1;
                if (last_reg) begin
                  LINK.gen_select_n <= 1'b1;
                  guard_reg <= 10'(GUARD_CYC - 1);
                  st_reg <= HS_GUARD;
                end else begin
                  WR_READY <= 1'b1;
                  st_reg <= HS_WAIT;
                end
              end
            end
          end
        end
        HS_GUARD: begin
          guard_reg <= guard_reg - 10'h001;
          if (guard_reg == 10'h000) begin
            WR_READY <= 1'b1;
            st_reg <= HS_IDLE;
          end
        end
        default: begin
          st_reg <= HS_IDLE;
        end
      endcase
    end
  end

  // Sample clock divider and 100-bit frame serialiser
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sdiv_reg <= 4'h0;
      fbit_reg <= 7'h00;
      frame_reg <= '0;
      cur_i_reg <= 16'h0000;
      cur_q_reg <= 16'h0000;
      S_READY <= 1'b0;
      LINK.sample_clock_p <= 1'b0;
      LINK.sample_clock_n <= 1'b1;
      LINK.sample_data_p <= 1'b0;
      LINK.sample_data_n <= 1'b1;
    end else begin
      S_READY <= 1'b0;
      sdiv_reg <= sdiv_reg + 4'h1;
      if (sdiv_reg == 4'(SCLK_HALF - 1)) begin
        sdiv_reg <= 4'h0;
        LINK.sample_clock_p <= !LINK.sample_clock_p;
        LINK.sample_clock_n <= LINK.sample_clock_p;
        if (!LINK.sample_clock_p) begin
          if (fbit_reg == 7'h00) begin
            // Stale sample repeats when none is offered
            frame_reg <= {WORD_SYNC, 1'b1, iqwg_fill(S_VALID ? S_I : cur_i_reg),
                          WORD_SYNC, 1'b0, iqwg_fill(S_VALID ? S_Q : cur_q_reg),
                          (FRAME_BITS - 2 * PORTION_BITS)'(0)} << 1;
            LINK.sample_data_p <= 1'b1;
            LINK.sample_data_n <= 1'b0;
            if (S_VALID) begin
              cur_i_reg <= S_I;
              cur_q_reg <= S_Q;
              S_READY <= 1'b1;
            end
          end else begin
            frame_reg <= frame_reg << 1;
            LINK.sample_data_p <= frame_reg[FRAME_BITS-1];
            LINK.sample_data_n <= !frame_reg[FRAME_BITS-1];
          end
          fbit_reg <= (fbit_reg == 7'(FRAME_BITS - 1)) ? 7'h00 : fbit_reg + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LINK.waveform_source_select <= 1'b0;
      LINK.gen_reset_n <= 1'b0;
    end else begin
      LINK.waveform_source_select <= USE_AUX;
      LINK.gen_reset_n <= !GEN_RESET;
    end
  end
endmodule : iqwg_host
`default_nettype wire

//--- iqwg_link_asserts.sv
// Concurrent checks on the link between the host and generator ends
`timescale 1ns/1ps
`default_nettype none
module iqwg_link_asserts
  import iqwg_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic spi_miso_oe_n,
  input wire logic gen_select_n,
  input wire logic sample_clock_p,
  input wire logic sample_clock_n,
  input wire logic sample_data_p,
  input wire logic sample_data_n
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // Cycles since deselect, saturating so the first select is legal
  logic [10:0] idle_cnt_reg;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      idle_cnt_reg <= 11'h7ff;
    end else if (!gen_select_n) begin
      idle_cnt_reg <= 11'h000;
    end else if (idle_cnt_reg != 11'h7ff) begin
      idle_cnt_reg <= idle_cnt_reg + 11'h001;
    end
  end

  a_guard_before_select: assert property (
    $fell(gen_select_n) |-> 32'(idle_cnt_reg) >= GUARD_CYC)
    else $error("select came back too early");
  a_sck_idle_low: assert property (
    gen_select_n |-> !spi_sck)
    else $error("serial clock active while deselected");
  a_mosi_stable_rise: assert property (
    $rose(spi_sck) |-> $stable(spi_mosi))
    else $error("data out changed at clock rise");
  a_sck_high_span: assert property (
    $rose(spi_sck) |-> ##8 $fell(spi_sck))
    else $error("serial clock high phase wrong");
  a_miso_released: assert property (
    gen_select_n [*5] |-> spi_miso_oe_n)
    else $error("data-out driven while deselected");
  a_clock_complement: assert property (
    sample_clock_n == !sample_clock_p)
    else $error("sample clock pair not complementary");
  a_data_complement: assert property (
    sample_data_n == !sample_data_p)
    else $error("sample data pair not complementary");
  a_data_on_rise: assert property (
    $changed(sample_data_p) |-> $rose(sample_clock_p))
    else $error("sample data changed off clock rise");
  a_sample_clock_rate: assert property (
    $rose(sample_clock_p) |-> ##10 $fell(sample_clock_p))
    else $error("sample clock half period wrong");

  c_select: cover property ($fell(gen_select_n));
  c_miso_driven: cover property (!spi_miso_oe_n);
  c_guard_done: cover property ($fell(gen_select_n) && idle_cnt_reg != 11'h7ff);
endmodule : iqwg_link_asserts
`default_nettype wire

//--- iq_waveform_gen_host_port_tb.sv
// Testbench joining the host and generator ends across the link
`timescale 1ns/1ps
`default_nettype none
module iq_waveform_gen_host_port_tb;
  import iqwg_pkg::*;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic WR_VALID = 1'b0;
  logic [7:0] WR_BYTE = 8'h00;
  logic WR_LAST = 1'b0;
  logic [15:0] S_I = 16'h0000;
  logic [15:0] S_Q = 16'h0000;
  logic S_VALID = 1'b0;
  logic SAMPLE_READY = 1'b1;
  logic USE_AUX = 1'b0;
  logic GEN_RESET = 1'b0;
  logic WR_READY, RD_VALID, S_READY, SAMPLE_VALID, SAMPLE_OVERFLOW, CHECKSUM_BUSY, ROUTE_AUX;
  logic [7:0] RD_BYTE;
  logic [15:0] I_DATA, Q_DATA, CHECKSUM;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  iqwg_link_if link();
  iqwg_device iqwg_device_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link), .I_DATA(I_DATA),
    .Q_DATA(Q_DATA), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
    .SAMPLE_OVERFLOW(SAMPLE_OVERFLOW), .CHECKSUM(CHECKSUM), .CHECKSUM_BUSY(CHECKSUM_BUSY),
    .ROUTE_AUX(ROUTE_AUX));
  iqwg_host iqwg_host_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link), .WR_VALID(WR_VALID),
    .WR_BYTE(WR_BYTE), .WR_LAST(WR_LAST), .WR_READY(WR_READY), .RD_BYTE(RD_BYTE),
    .RD_VALID(RD_VALID), .S_I(S_I), .S_Q(S_Q), .S_VALID(S_VALID), .S_READY(S_READY),
    .USE_AUX(USE_AUX), .GEN_RESET(GEN_RESET));
  iqwg_link_asserts iqwg_link_asserts_inst (.CLK(CLK), .RSTN(RSTN),
    .spi_sck(link.spi_sck), .spi_mosi(link.spi_mosi), .spi_miso_oe_n(link.spi_miso_oe_n),
    .gen_select_n(link.gen_select_n), .sample_clock_p(link.sample_clock_p),
    .sample_clock_n(link.sample_clock_n), .sample_data_p(link.sample_data_p),
    .sample_data_n(link.sample_data_n));

  always #5 CLK = ~CLK;
  always @(posedge CLK) cyc++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic wait_hi(ref logic sig, input int lim);
    int i;
    for (i = 0; i < lim && sig !== 1'b1; i++) @(negedge CLK);
    if (sig !== 1'b1) fails++;
  endtask : wait_hi

  // One byte shifted each way; returns the byte read back
  task automatic send_byte(input logic [7:0] b, input logic last, output logic [7:0] rd);
    wait_hi(WR_READY, 2000);
    WR_VALID = 1'b1;
    WR_BYTE = b;
    WR_LAST = last;
    @(negedge CLK);
    WR_VALID = 1'b0;
    WR_LAST = 1'b0;
    wait_hi(RD_VALID, 200);
    rd = RD_BYTE;
    @(negedge CLK);
  endtask : send_byte

  task automatic session(input logic [7:0] b[$], output logic [7:0] rd[$]);
    logic [7:0] r;
    rd = {};
    foreach (b[k]) begin
      send_byte(b[k], k == b.size() - 1, r);
      rd.push_back(r);
    end
    wait_hi(WR_READY, 1000);
    check({31'h0, CHECKSUM_BUSY}, 32'h0);
  endtask : session

  task automatic t_reset_values;
    check({CHECKSUM, 13'h0, CHECKSUM_BUSY, SAMPLE_VALID, link.spi_miso_oe_n}, 32'h1);
  endtask : t_reset_values

  task automatic t_write_sum;
    logic [7:0] rd[$];
    session({8'h05, 8'h3f, 8'hd8, 8'h2c}, rd);
    check({16'h0, rd[0], rd[1]}, 32'h0);
    check({16'h0, CHECKSUM}, 32'h8143);
  endtask : t_write_sum

  task automatic t_read_back;
    logic [7:0] b[$];
    logic [7:0] rd[$];
    logic [7:0] e[8];
    e = '{8'h81, 8'h43, TEST_BYTE0, TEST_BYTE1, TEST_BYTE2, TEST_BYTE3, 8'h81, 8'h43};
    b = {8'h1a};
    repeat (7) b.push_back(8'h00);
    session(b, rd);
    for (int k = 0; k < 8; k++) check({24'h0, rd[k]}, {24'h0, e[k]});
    check({16'h0, CHECKSUM}, 32'h8143);
  endtask : t_read_back

  task automatic t_top_regs;
    logic [7:0] rd[$];
    session({8'h18, 8'h01, 8'h02, 8'hff}, rd);
    check({16'h0, rd[0], rd[1]}, 32'h8143);
    check({16'h0, CHECKSUM}, 32'h8146);
  endtask : t_top_regs

  task automatic t_route;
    USE_AUX = 1'b1;
    repeat (6) @(negedge CLK);
    check({31'h0, ROUTE_AUX}, 32'h1);
    USE_AUX = 1'b0;
    repeat (6) @(negedge CLK);
    check({31'h0, ROUTE_AUX}, 32'h0);
  endtask : t_route

  // Six samples into a four-deep buffer with the consumer stalled
  task automatic t_samples;
    int t0;
    logic [15:0] iv;
    S_VALID = 1'b1;
    for (int k = 0; k < 6; k++) begin
      S_I = 16'h8421 ^ {4{4'(k)}};
      S_Q = ~S_I;
      wait_hi(S_READY, 2100);
      if (k == 0) begin
        SAMPLE_READY = 1'b0;
        t0 = cyc;
      end
      if (k == 1) check(32'(cyc - t0), 32'(FRAME_BITS * 2 * SCLK_HALF));
      @(negedge CLK);
    end
    S_VALID = 1'b0;
    repeat (2200) @(negedge CLK);
    check({31'h0, SAMPLE_OVERFLOW}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      iv = 16'h8421 ^ {4{4'(k)}};
      check({31'h0, SAMPLE_VALID}, 32'h1);
      check({I_DATA, Q_DATA}, {iv, ~iv});
      SAMPLE_READY = 1'b1;
      @(negedge CLK);
      SAMPLE_READY = 1'b0;
      @(negedge CLK);
    end
    SAMPLE_READY = 1'b1;
    repeat (10) @(negedge CLK);
    check({31'h0, SAMPLE_VALID}, 32'h0);
  endtask : t_samples

  task automatic t_gen_reset;
    GEN_RESET = 1'b1;
    repeat (10) @(negedge CLK);
    check({16'h0, CHECKSUM}, 32'h0);
    GEN_RESET = 1'b0;
    repeat (10) @(negedge CLK);
  endtask : t_gen_reset

  initial begin
    repeat (2) @(negedge CLK);
    RSTN = 1'b1;
    repeat (8) @(negedge CLK);
    t_reset_values();
    t_write_sum();
    t_read_back();
    t_top_regs();
    t_route();
    t_samples();
    t_gen_reset();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge CLK);
    fails++;
    complete_run();
  end
endmodule : iq_waveform_gen_host_port_tb
`default_nettype wire
